// [hdl/async_serial_transmitter.sv]
/*
 Asynchronous serial transmitter with a small break-detecting receiver,
 APB register slave and 16x sampling-clock divider.
 Assumes an APB master on ref_clk and a pulled-up open-drain transmit line.
*/
// The implementer's own choice: the APB interface to the registers.
// Overview of operation
// - Characters are eight or nine data bits
// - Ninth bit comes from control three
// - Data buffer feeds the transmit shift register
// - Transmission starts with an all-ones preamble
// - Low start bit, high stop bit
// - Buffer hand-off sets empty flag, may interrupt
// - Line idles high between characters
// - Module disable releases the port pins
// - Send-break loads all-zero break character
// - Breaks repeat, then at least one high
// - All-zero frame received means break
// - Received break sets error, full, break flags
// - Idle character is all ones, length selectable
// - Disabling transmitter finishes current character first
// - Enable toggle queues one idle character
// - Inversion bit inverts every transmitted level
// - Complete flag means nothing left to send
// - Transmitter and receiver share one baud tick
// - Config two bit selects baud source
// - Reset shows empty and complete flags set
// - Each bit lasts sixteen sampling periods
`timescale 1ns/1ps
module async_serial_transmitter (
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [9:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Serial line
    input  wire logic                rx_line,
    output serial_tx_pkg::pin_t      tx_pin,
    // Transmitter interrupt request
    output logic                     tx_irq
);
    typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;
    typedef enum {RX_IDLE, RX_BUSY} rx_state_t;

    logic [7:0]               ctrl1_r;        // Control one
    logic [7:0]               ctrl2_r;        // Control two
    logic [7:0]               ctrl3_r;        // Control three, bit 7 unused here
    logic [7:0]               baud_r;         // Baud prescale and rate
    logic [7:0]               cfg2_r;         // Device configuration two
    logic [31:0]              prdata_r;       // Read data
    logic                     pready_r;       // Access-phase ready
    logic                     pslverr_r;      // Unmapped access
    logic                     hit;            // Address decodes
    logic [7:0]               rmux;           // Read mux
    logic                     acc;            // Access completes
    logic                     wr;             // Write takes effect
    logic                     rd;             // Read takes effect
    logic [7:0]               idx;            // Register index
    logic [7:0]               hold_r;         // Transmit data buffer
    logic                     tx_buffer_empty_flag_r;         // Buffer empty flag
    logic                     tc_r;           // Transmission complete flag
    logic                     armed_r;        // Status read seen with empty set
    logic                     src_tog_r;      // Half-rate source toggle
    logic [9:0]               div_r;          // Baud divider count
    logic [9:0]               div_lim;        // Divider terminal count
    logic                     rt_tick;        // Sampling-clock enable
    logic                     rt_tick_r;      // Registered sampling enable
    tx_state_t                tx_state_r;     // Transmit state
    logic [10:0]              shift_r;        // Transmit shift register
    logic [3:0]               bits_r;         // Bits left in frame
    logic [3:0]               rt_r;           // Transmit bit phase
    logic                     te_prev_r;      // Last transmitter enable
    logic                     idle_pend_r;    // Idle character queued
    logic                     tail_pend_r;    // High bit owed after break
    serial_tx_pkg::load_kind_t kind;          // Next frame kind
    logic                     load_now;       // Load at this edge
    logic [3:0]               flen;           // Frame length in bits
    logic                     line;           // Uninverted line level
    serial_tx_pkg::pin_t      pin_r;          // Registered pin drive
    logic                     irq_r;          // Registered interrupt
    rx_state_t                rx_state_r;     // Receive state
    logic [3:0]               rx_rt_r;        // Receive bit phase
    logic [3:0]               rx_bit_r;       // Receive bit index
    logic [8:0]               rx_sh_r;        // Receive shift register
    logic [7:0]               rx_data_r;      // Receive data buffer
    logic                     rx9_r;          // Received ninth bit
    logic                     full_r;         // Receive full flag
    logic                     fe_r;           // Framing error flag
    logic                     bkf_r;          // Break flag
    logic                     rx_done;        // Stop bit sampled
    logic                     rx_brk;         // Finished frame is a break

    wire en   = ctrl1_r[serial_tx_pkg::C1_ENABLE];
    wire len9 = ctrl1_r[serial_tx_pkg::C1_LEN9];
    wire te   = ctrl2_r[serial_tx_pkg::C2_TX_EN];
    wire send_break_bit  = ctrl2_r[serial_tx_pkg::C2_BREAK];

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign tx_pin  = pin_r;
    assign tx_irq  = irq_r;

    // APB phase decode; every access has one wait-free access phase
    assign idx = paddr[9:2];
    assign acc = psel & penable & pready_r;
    assign wr  = acc & pwrite & ~pslverr_r;
    assign rd  = acc & ~pwrite & ~pslverr_r;
    assign flen = len9 ? serial_tx_pkg::FRAME_9 : serial_tx_pkg::FRAME_8;

    // Address decode and read mux
    always_comb begin
        hit  = 1'b1;
        rmux = 8'h00;
        unique case (idx)
            serial_tx_pkg::IDX_CTRL_ONE:   rmux = ctrl1_r;
            serial_tx_pkg::IDX_CTRL_TWO:   rmux = ctrl2_r;
            serial_tx_pkg::IDX_CTRL_THREE: rmux = {rx9_r, ctrl3_r[6:0]};
            serial_tx_pkg::IDX_STAT_ONE:   rmux = {tx_buffer_empty_flag_r, tc_r, full_r, 3'h0, fe_r, 1'b0};
            serial_tx_pkg::IDX_STAT_TWO:   rmux = {6'h00, bkf_r, rx_state_r == RX_BUSY};
            serial_tx_pkg::IDX_DATA:       rmux = rx_data_r;
            serial_tx_pkg::IDX_BAUD:       rmux = {2'h0, baud_r[5:4], 1'b0, baud_r[2:0]};
            serial_tx_pkg::IDX_CONFIG_TWO: rmux = cfg2_r;
            default:                       hit  = 1'b0;
        endcase
    end

    // APB answer: ready and data in the first access cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= psel & ~penable;
            pslverr_r <= psel & ~penable & ~hit;
            if (psel & ~penable) begin
                prdata_r <= {24'h00_0000, rmux};
            end
        end
    end

    // Control registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl1_r <= serial_tx_pkg::CTRL_RESET;
            ctrl2_r <= serial_tx_pkg::CTRL_RESET;
            ctrl3_r <= serial_tx_pkg::CTRL_RESET;
            baud_r  <= serial_tx_pkg::CTRL_RESET;
            cfg2_r  <= serial_tx_pkg::CONFIG_RESET;
        end else if (wr) begin
            unique case (idx)
                serial_tx_pkg::IDX_CTRL_ONE:   ctrl1_r <= pwdata[7:0];
                serial_tx_pkg::IDX_CTRL_TWO:   ctrl2_r <= pwdata[7:0];
                serial_tx_pkg::IDX_CTRL_THREE: ctrl3_r <= {1'b0, pwdata[6:0]};
                serial_tx_pkg::IDX_BAUD:       baud_r  <= pwdata[7:0];
                serial_tx_pkg::IDX_CONFIG_TWO: cfg2_r  <= pwdata[7:0];
                default:                       ;
            endcase
        end
    end

    // Baud divider: one tick serves both directions
    assign div_lim = 10'((({1'b0, baud_r[5:serial_tx_pkg::BAUD_PRE_LO]} + 3'h1)
                     << baud_r[serial_tx_pkg::BAUD_RATE_HI:0]) - 1);
    assign rt_tick = en & (src_tog_r | ~cfg2_r[serial_tx_pkg::CFG_BAUD_SRC]) & (div_r == div_lim);

    // Source prescale and divider count
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            src_tog_r <= 1'b0;
            div_r     <= 10'h000;
            rt_tick_r <= 1'b0;
        end else begin
            src_tog_r <= ~src_tog_r;
            rt_tick_r <= rt_tick;
            if (!en) begin
                div_r <= 10'h000;
            end else if (src_tog_r | ~cfg2_r[serial_tx_pkg::CFG_BAUD_SRC]) begin
                div_r <= (div_r >= div_lim) ? 10'h000 : div_r + 10'h001;
            end
        end
    end

    // Frame choice at a boundary: idle, break, tail, then data
    always_comb begin
        kind = serial_tx_pkg::LD_NONE;
        if (te) begin
            if (idle_pend_r) begin
                kind = serial_tx_pkg::LD_IDLE;
            end else if (send_break_bit) begin
                kind = serial_tx_pkg::LD_BREAK;
            end else if (tail_pend_r) begin
                kind = serial_tx_pkg::LD_TAIL;
            end else if (!tx_buffer_empty_flag_r) begin
                kind = serial_tx_pkg::LD_DATA;
            end
        end
        // Module enable gates the load so a stale tick cannot hand off after disable
        load_now = en & rt_tick_r & (kind != serial_tx_pkg::LD_NONE)
                 & ((tx_state_r == TX_IDLE) | ((rt_r == serial_tx_pkg::RT_LAST) & (bits_r == 4'h1)));
    end

    // Transmit shifter, one bit per sixteen ticks
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_state_r <= TX_IDLE;
            shift_r    <= 11'h7FF;
            bits_r     <= 4'h0;
            rt_r       <= 4'h0;
        end else if (!en) begin
            tx_state_r <= TX_IDLE;
            shift_r    <= 11'h7FF;
        end else if (load_now) begin
            tx_state_r <= TX_SHIFT;
            rt_r       <= 4'h0;
            bits_r     <= flen;
            unique case (kind)
                serial_tx_pkg::LD_IDLE:  shift_r <= 11'h7FF;
                serial_tx_pkg::LD_BREAK: shift_r <= 11'h000;
                serial_tx_pkg::LD_TAIL: begin
                    shift_r <= 11'h7FF;
                    bits_r  <= 4'h1;
                end
                default: shift_r <= {1'b1, len9 ? ctrl3_r[serial_tx_pkg::C3_TX9] : 1'b1, hold_r, 1'b0};
            endcase
        end else if (rt_tick_r && tx_state_r == TX_SHIFT) begin
            rt_r <= rt_r + 4'h1;
            if (rt_r == serial_tx_pkg::RT_LAST) begin
                shift_r <= {1'b1, shift_r[10:1]};
                bits_r  <= bits_r - 4'h1;
                if (bits_r == 4'h1) begin
                    tx_state_r <= TX_IDLE;
                end
            end
        end
    end

    // Queued idle and post-break tail; a new request beats the clear
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            te_prev_r   <= 1'b0;
            idle_pend_r <= 1'b0;
            tail_pend_r <= 1'b0;
        end else begin
            te_prev_r <= te;
            if (load_now && kind == serial_tx_pkg::LD_IDLE) begin
                idle_pend_r <= 1'b0;
            end
            if (te && !te_prev_r) begin
                idle_pend_r <= 1'b1;
            end
            if (load_now && kind == serial_tx_pkg::LD_TAIL) begin
                tail_pend_r <= 1'b0;
            end
            if (load_now && kind == serial_tx_pkg::LD_BREAK) begin
                tail_pend_r <= 1'b1;
            end
        end
    end

    // Data buffer and empty flag; hand-off sets beat a clearing write
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_r  <= 8'h00;
            tx_buffer_empty_flag_r  <= 1'b1;
            armed_r <= 1'b0;
        end else begin
            if (rd && idx == serial_tx_pkg::IDX_STAT_ONE && tx_buffer_empty_flag_r) begin
                armed_r <= 1'b1;
            end
            if (wr && idx == serial_tx_pkg::IDX_DATA) begin
                hold_r  <= pwdata[7:0];
                armed_r <= 1'b0;
                if (armed_r) begin
                    tx_buffer_empty_flag_r <= 1'b0;
                end
            end
            if (load_now && kind == serial_tx_pkg::LD_DATA) begin
                tx_buffer_empty_flag_r <= 1'b1;
            end
        end
    end

    // Line level, inversion, open-drain drive, interrupt request
    assign line = (tx_state_r == TX_SHIFT) ? shift_r[0] : 1'b1;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_r <= '{o: 1'b0, oe: 1'b0};
            tc_r  <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            pin_r.o  <= 1'b0;
            pin_r.oe <= en & ~(line ^ ctrl1_r[serial_tx_pkg::C1_INVERT]);
            tc_r     <= (tx_state_r == TX_IDLE) & tx_buffer_empty_flag_r & ~idle_pend_r & ~tail_pend_r & ~send_break_bit;
            irq_r    <= (tx_buffer_empty_flag_r & ctrl2_r[serial_tx_pkg::C2_TE_IRQ])
                      | (tc_r & ctrl2_r[serial_tx_pkg::C2_TC_IRQ]);
        end
    end

    // Receive end of frame and break recognition
    assign rx_done = rt_tick_r & (rx_state_r == RX_BUSY) & (rx_rt_r == serial_tx_pkg::RT_SAMPLE)
                   & (rx_bit_r == flen - 4'h1);
    assign rx_brk  = ~rx_line & ((len9 ? rx_sh_r : {1'b0, rx_sh_r[8:1]}) == 9'h000);

    // Receiver sampling at mid-bit
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_state_r <= RX_IDLE;
            rx_rt_r    <= 4'h0;
            rx_bit_r   <= 4'h0;
            rx_sh_r    <= 9'h000;
        end else if (!en || !ctrl2_r[serial_tx_pkg::C2_RX_EN]) begin
            rx_state_r <= RX_IDLE;
        end else if (rt_tick_r) begin
            if (rx_state_r == RX_IDLE) begin
                if (!rx_line) begin
                    rx_state_r <= RX_BUSY;
                    rx_rt_r    <= 4'h0;
                    rx_bit_r   <= 4'h0;
                end
            end else begin
                rx_rt_r <= rx_rt_r + 4'h1;
                if (rx_rt_r == serial_tx_pkg::RT_SAMPLE) begin
                    rx_bit_r <= rx_bit_r + 4'h1;
                    if (rx_bit_r == 4'h0 && rx_line) begin
                        rx_state_r <= RX_IDLE;
                    end else if (rx_done) begin
                        rx_state_r <= RX_IDLE;
                    end else if (rx_bit_r != 4'h0) begin
                        rx_sh_r <= {rx_line, rx_sh_r[8:1]};
                    end
                end
            end
        end
    end

    // Receive flags: data read or status two read clears, setting wins
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_data_r <= 8'h00;
            rx9_r     <= 1'b0;
            full_r    <= 1'b0;
            fe_r      <= 1'b0;
            bkf_r     <= 1'b0;
        end else begin
            if (rd && idx == serial_tx_pkg::IDX_DATA) begin
                full_r <= 1'b0;
                fe_r   <= 1'b0;
            end
            if (rd && idx == serial_tx_pkg::IDX_STAT_TWO) begin
                bkf_r <= 1'b0;
            end
            if (rx_done) begin
                full_r    <= 1'b1;
                fe_r      <= ~rx_line;
                bkf_r     <= bkf_r | rx_brk;
                rx_data_r <= rx_brk ? 8'h00 : (len9 ? rx_sh_r[7:0] : rx_sh_r[8:1]);
                rx9_r     <= rx_brk ? 1'b0 : rx_sh_r[8];
            end
        end
    end

    // Checks next to the logic
    sequence s_data_load;
        load_now && kind == serial_tx_pkg::LD_DATA;
    endsequence
    sequence s_break_load;
        load_now && kind == serial_tx_pkg::LD_BREAK;
    endsequence

    a_data_framing: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_data_load |=> (shift_r[0] == 1'b0) && shift_r[10] && (bits_r == flen))
        else $error("data frame lacks start or stop bit");
    a_ninth_bit: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (s_data_load and len9) |=> shift_r[9] == $past(ctrl3_r[serial_tx_pkg::C3_TX9]))
        else $error("ninth bit not taken from control three");
    a_empty_on_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_data_load ##1 1'b1 |-> tx_buffer_empty_flag_r && tx_state_r == TX_SHIFT)
        else $error("empty flag not set on hand-off");
    a_break_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_break_load |=> shift_r == 11'h000 ##1 tail_pend_r)
        else $error("break character not all zeros");
    a_load_needs_te: assert property (@(posedge ref_clk) disable iff (!arst_n)
        load_now |-> te && $past(rt_tick))
        else $error("frame loaded with transmitter disabled");
    a_idle_high: assert property (@(posedge ref_clk) disable iff (!arst_n)
        tx_state_r == TX_IDLE && en && !ctrl1_r[serial_tx_pkg::C1_INVERT] |=> !tx_pin.oe)
        else $error("idle line not high");
    a_disable_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !en |=> !tx_pin.oe && tx_state_r == TX_IDLE)
        else $error("pin driven while module disabled");
    a_invert_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
        tx_state_r == TX_IDLE && en && ctrl1_r[serial_tx_pkg::C1_INVERT] |=> tx_pin.oe)
        else $error("inverted idle not driven low");
    a_complete_means: assert property (@(posedge ref_clk) disable iff (!arst_n)
        tc_r |-> $past(tx_buffer_empty_flag_r) && $past(tx_state_r == TX_IDLE) && !$past(idle_pend_r))
        else $error("complete flag with work pending");
    a_break_flags: assert property (@(posedge ref_clk) disable iff (!arst_n)
        rx_done && rx_brk |=> full_r && fe_r && bkf_r && rx_data_r == 8'h00 && !rx9_r)
        else $error("received break flags wrong");
    a_bit_period: assert property (@(posedge ref_clk) disable iff (!arst_n)
        tx_state_r == TX_SHIFT && rt_tick_r && rt_r != serial_tx_pkg::RT_LAST && !load_now && en
        |=> bits_r == $past(bits_r))
        else $error("bit ended before sixteen ticks");
endmodule

// [hdl/serial_tx_pkg.sv]
/*
 Constants and types for the asynchronous serial transmitter block:
 register indices, field positions, reset values and frame timing.
 Assumes an APB master with 32-bit data; each register takes one aligned
 word whose byte address is four times its index.
*/
package serial_tx_pkg;
    // Register indices (byte address = index * 4)
    localparam logic [7:0] IDX_CTRL_ONE   = 8'h13;
    localparam logic [7:0] IDX_CTRL_TWO   = 8'h14;
    localparam logic [7:0] IDX_CTRL_THREE = 8'h15;
    localparam logic [7:0] IDX_STAT_ONE   = 8'h16;
    localparam logic [7:0] IDX_STAT_TWO   = 8'h17;
    localparam logic [7:0] IDX_DATA       = 8'h18;
    localparam logic [7:0] IDX_BAUD       = 8'h19;
    localparam logic [7:0] IDX_CONFIG_TWO = 8'h1D;
    // Control one fields
    localparam int C1_ENABLE = 6;
    localparam int C1_INVERT = 5;
    localparam int C1_LEN9   = 4;
    // Control two fields
    localparam int C2_TE_IRQ = 7;
    localparam int C2_TC_IRQ = 6;
    localparam int C2_TX_EN  = 3;
    localparam int C2_RX_EN  = 2;
    localparam int C2_BREAK  = 0;
    // Control three fields
    localparam int C3_RX9 = 7;
    localparam int C3_TX9 = 6;
    // Status one fields
    localparam int S1_EMPTY = 7;
    localparam int S1_DONE  = 6;
    localparam int S1_FULL  = 5;
    localparam int S1_FRAME = 1;
    // Status two fields
    localparam int S2_BREAK = 1;
    localparam int S2_BUSY  = 0;
    // Configuration two: baud source select position
    localparam int CFG_BAUD_SRC = 0;
    // Baud register fields
    localparam int BAUD_PRE_LO  = 4;
    localparam int BAUD_RATE_HI = 2;
    // Reset values
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    // Frame timing in sampling-clock periods and bits
    localparam logic [3:0] RT_LAST   = 4'hF;
    localparam logic [3:0] RT_SAMPLE = 4'h7;
    localparam logic [3:0] FRAME_8   = 4'hA;
    localparam logic [3:0] FRAME_9   = 4'hB;
    // Frame kinds chosen at a frame boundary
    typedef enum {LD_NONE, LD_IDLE, LD_BREAK, LD_TAIL, LD_DATA} load_kind_t;
    // Open-drain transmit pin
    typedef struct packed {
        logic o;
        logic oe;
    } pin_t;
endpackage

// [testbench/serial_far_end.sv]
/* Far-end serial peer: decodes frames seen on the transmit line and sends breaks on the receive line.
   Assumes a pulled-up open-drain line and sixteen ref_clk periods per bit. */
`timescale 1ns/1ps
module serial_far_end (
    // Line side
    input  wire logic           ref_clk,
    input  serial_tx_pkg::pin_t tx_pin,
    input  wire logic           inv,
    input  wire logic           nine,
    input  wire logic           brk_req,
    output logic                rx_line,
    // Decoded frames
    output logic [9:0]          got_r,
    output int                  frames_r
);
    logic       lvl;  // Line level with inversion undone
    logic [4:0] hi_r; // Run of idle-high clocks
    assign lvl = (!tx_pin.oe) ^ inv;
    initial begin
        rx_line = 1'b1;
        frames_r = 0;
        hi_r = 5'h00;
    end
    // Idle run counter guards against glitches on mode changes
    always @(posedge ref_clk) hi_r <= lvl ? (hi_r == 5'h1F ? hi_r : hi_r + 5'h01) : 5'h00;
    // Start after idle, then sample each bit in its middle
    // A start that is high again at mid-bit is a polarity glitch, not a frame
    always begin
        @(posedge ref_clk iff (lvl === 1'b0 && hi_r > 5'h0B));
        repeat (8) @(posedge ref_clk);
        if (lvl === 1'b0) begin
            got_r = 10'h000;
            for (int i = 0; i < (nine ? 10 : 9); i++) begin
                repeat (16) @(posedge ref_clk);
                got_r[i] = lvl;
            end
            frames_r++;
        end
    end
    // Remote break: eleven bit times low
    always @(posedge brk_req) begin
        rx_line <= 1'b0;
        repeat (176) @(posedge ref_clk);
        rx_line <= 1'b1;
    end
endmodule

// [testbench/tb_top.sv]
/* Self-checking bench for the serial transmitter: APB register traffic and a far-end peer.
   Assumes reset baud settings, so one sampling tick per ref_clk. */
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, rx_line, tx_irq, inv = 1'b0, nine = 1'b0, brk_req = 1'b0, err, t8;
    serial_tx_pkg::pin_t tx_pin;
    logic [9:0] got;
    logic [7:0] rd, b, c;
    int frames, errors = 0, samples_checked = 0, cyc = 0, seed = 32'hD95E9043;
    always #20 ref_clk = ~ref_clk;
    async_serial_transmitter u_async_serial_transmitter (.ref_clk, .arst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_line, .tx_pin, .tx_irq);
    serial_far_end u_serial_far_end (.ref_clk, .tx_pin, .inv, .nine, .brk_req, .rx_line,
        .got_r(got), .frames_r(frames));
    task automatic report_and_stop;
        if (errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [9:0] g, input logic [9:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // One APB transfer; answer taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        // Answer sampled only at rising edges; a lost answer ends in the hang guard
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        check({2'b00, rd & m}, {2'b00, e});
    endtask
    task automatic frame(input logic [9:0] e);
        int f;
        f = frames;
        while (frames == f) @(posedge ref_clk);
        check(got, e);
    endtask
    // Expected decode: data LSB first, then ninth bit and stop, or stop and a zero
    function automatic logic [9:0] fexp(input logic [7:0] d);
        return nine ? {1'b1, t8, d} : {2'b01, d};
    endfunction
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc > 20000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdchk(8'h16, 8'hFF, 8'hC0);
        apb(1'b0, 8'h00, 8'h00);
        check({9'h0, err}, 10'h001);
        apb(1'b1, 8'h1D, 8'h01);
        rdchk(8'h1D, 8'hFF, 8'h01);
        apb(1'b1, 8'h1D, 8'h00);
        for (int m = 0; m < 3; m++) begin
            t8 = 1'($random(seed));
            apb(1'b1, 8'h14, 8'h00);
            apb(1'b1, 8'h13, 8'h40 | (m == 1 ? 8'h10 : 8'h00) | (m == 2 ? 8'h20 : 8'h00));
            nine <= (m == 1);
            inv <= (m == 2);
            apb(1'b1, 8'h15, {1'b0, t8, 6'h00});
            apb(1'b1, 8'h14, 8'h48);
            c = 8'($random(seed));
            do apb(1'b0, 8'h16, 8'h00); while (rd[7] !== 1'b1);
            apb(1'b1, 8'h18, c);
            b = 8'($random(seed));
            do apb(1'b0, 8'h16, 8'h00); while (rd[7] !== 1'b1);
            // Queue an idle while the first byte is still shifting
            apb(1'b1, 8'h14, 8'h40);
            apb(1'b1, 8'h14, 8'h48);
            apb(1'b1, 8'h18, b);
            frame(fexp(c));
            frame(fexp(b));
            repeat (40) @(posedge ref_clk);
            rdchk(8'h16, 8'hC0, 8'hC0);
            check({9'h0, tx_irq}, 10'h001);
        end
        apb(1'b1, 8'h14, 8'h4D);
        frame(10'h000);
        brk_req <= 1'b1;
        repeat (250) @(posedge ref_clk);
        rdchk(8'h16, 8'h22, 8'h22);
        rdchk(8'h17, 8'h02, 8'h02);
        rdchk(8'h18, 8'hFF, 8'h00);
        apb(1'b1, 8'h13, 8'h40);
        repeat (40) @(posedge ref_clk);
        check({9'h0, tx_pin.oe}, 10'h001);
        apb(1'b1, 8'h13, 8'h00);
        repeat (2) @(posedge ref_clk);
        check({9'h0, tx_pin.oe}, 10'h000);
        report_and_stop();
    end
endmodule
